//--- src/fmc_rx_dec.sv
// Receive decoder: code-groups to octets with frame checks.
`include "fmc_consts.svh"
module fmc_rx_dec (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic [4:0]              rx_cg,
  output fmc_pkg::fmc_oct_type         rx_oct,
  output logic                         rx_sof,
  output logic                         rx_eof,
  output fmc_pkg::fmc_rxstat_type      rx_stat
);
  typedef enum logic [1:0] {FMC_RX_IDLE, FMC_RX_SSD2, FMC_RX_DATA, FMC_RX_ESD2} fmc_rxst_type;

  // ==========================================================
  // Decoding
  function automatic logic [4:0] fmc_dec(input logic [4:0] cg);
    // Bit 4 marks a valid data code-group.
    unique case (cg)
      5'h1E: return 5'h10;
      5'h09: return 5'h11;
      5'h14: return 5'h12;
      5'h15: return 5'h13;
      5'h0A: return 5'h14;
      5'h0B: return 5'h15;
      5'h0E: return 5'h16;
      5'h0F: return 5'h17;
      5'h12: return 5'h18;
      5'h13: return 5'h19;
      5'h16: return 5'h1A;
      5'h17: return 5'h1B;
      5'h1A: return 5'h1C;
      5'h1B: return 5'h1D;
      5'h1C: return 5'h1E;
      5'h1D: return 5'h1F;
      default: return 5'h00;
    endcase
  endfunction

  function automatic logic [31:0] fmc_crc8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `FMC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  wire [4:0] dec_w      = fmc_dec(rx_cg);
  wire       is_data_w  = dec_w[4];
  wire       is_idle_w  = rx_cg == `FMC_CG_IDLE;
  wire       is_txerr_w = rx_cg == `FMC_CG_TXERR;
  wire       is_ctl_w   = is_idle_w | is_txerr_w | rx_cg == `FMC_CG_SSD1 |
                          rx_cg == `FMC_CG_SSD2 | rx_cg == `FMC_CG_ESD1 | rx_cg == `FMC_CG_ESD2;
  wire       is_inv_w   = !is_data_w && !is_ctl_w;

  fmc_rxst_type st_r;
  logic         half_r;
  logic [3:0]   hi_r;
  logic [31:0]  crc_r;
  logic [10:0]  cnt_r;
  logic         bad_r;

  wire        oct_done_w = st_r == FMC_RX_DATA && is_data_w && half_r;
  wire [7:0]  oct_w      = {hi_r, dec_w[3:0]};
  wire        at_end_w   = st_r == FMC_RX_ESD2;
  wire        end_ok_w   = at_end_w && rx_cg == `FMC_CG_ESD2;
  wire        fcs_bad_w  = crc_r != `FMC_CRC_RES;
  wire        len_bad_w  = cnt_r < `FMC_HDR_OCT + `FMC_MIN_OCT + `FMC_FCS_OCT ||
                           cnt_r > `FMC_HDR_OCT + `FMC_MAX_OCT + `FMC_FCS_OCT || half_r;
  wire        err_w      = st_r == FMC_RX_DATA && (is_inv_w || is_txerr_w);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= FMC_RX_IDLE;
      half_r  <= 1'b0;
      hi_r    <= 4'h0;
      crc_r   <= `FMC_CRC_INIT;
      cnt_r   <= 11'h000;
      bad_r   <= 1'b0;
      rx_oct  <= '0;
      rx_sof  <= 1'b0;
      rx_eof  <= 1'b0;
      rx_stat <= '0;
    end else begin
      rx_oct  <= '{valid: oct_done_w, data: oct_w, err: err_w};
      rx_sof  <= st_r == FMC_RX_SSD2 && rx_cg == `FMC_CG_SSD2;
      rx_eof  <= at_end_w;
      // No retransmission is requested; status only reports.
      rx_stat <= '{frame_ok: end_ok_w && !fcs_bad_w && !len_bad_w && !bad_r,
                   fcs_bad: at_end_w && fcs_bad_w, len_bad: at_end_w && len_bad_w,
                   code_bad: (at_end_w && (bad_r || !end_ok_w)) || is_inv_w};
      unique case (st_r)
        FMC_RX_IDLE: begin
          if (rx_cg == `FMC_CG_SSD1) begin
            st_r <= FMC_RX_SSD2;
          end
        end
        FMC_RX_SSD2: begin
          half_r <= 1'b0;
          crc_r  <= `FMC_CRC_INIT;
          cnt_r  <= 11'h000;
          bad_r  <= 1'b0;
          st_r   <= rx_cg == `FMC_CG_SSD2 ? FMC_RX_DATA : FMC_RX_IDLE;
        end
        FMC_RX_DATA: begin
          if (is_data_w) begin
            half_r <= !half_r;
            hi_r   <= dec_w[3:0];
            if (half_r) begin
              crc_r <= fmc_crc8(crc_r, oct_w);
              if (cnt_r != 11'h7FF) begin
                cnt_r <= cnt_r + 11'h001;
              end
            end
          end else if (rx_cg == `FMC_CG_ESD1) begin
            st_r <= FMC_RX_ESD2;
          end else if (is_idle_w) begin
            bad_r <= 1'b1;
            st_r  <= FMC_RX_ESD2;
          end else begin
            bad_r <= 1'b1;
          end
        end
        FMC_RX_ESD2: begin
          st_r <= FMC_RX_IDLE;
        end
      endcase
    end
  end

  property p_rx_sof_pair;
    @(posedge core_clk) disable iff (!rst_n)
      (st_r == FMC_RX_IDLE && rx_cg == `FMC_CG_SSD1) ##1 (rx_cg == `FMC_CG_SSD2) |=> rx_sof;
  endproperty
  a_rx_sof_pair: assert property (p_rx_sof_pair) else $error("start pair not reported");

  property p_rx_inv;
    @(posedge core_clk) disable iff (!rst_n)
      (rx_cg == 5'h00 || rx_cg == 5'h10 || rx_cg == 5'h19) |=> rx_stat.code_bad;
  endproperty
  a_rx_inv: assert property (p_rx_inv) else $error("invalid code not flagged");

  property p_rx_idle_nodata;
    @(posedge core_clk) disable iff (!rst_n)
      is_idle_w |=> !rx_oct.valid;
  endproperty
  a_rx_idle_nodata: assert property (p_rx_idle_nodata) else $error("idle gave data");

  property p_rx_txerr;
    @(posedge core_clk) disable iff (!rst_n)
      (st_r == FMC_RX_DATA && is_txerr_w) |=> rx_oct.err;
  endproperty
  a_rx_txerr: assert property (p_rx_txerr) else $error("transmit error missed");
endmodule

//--- src/fmc_consts.svh
// Constants for the fast management 4B/5B coding sublayer.
`ifndef FMC_CONSTS_SVH
`define FMC_CONSTS_SVH
`define FMC_CG_IDLE   5'h1F
`define FMC_CG_SSD1   5'h18
`define FMC_CG_SSD2   5'h11
`define FMC_CG_ESD1   5'h0D
`define FMC_CG_ESD2   5'h07
`define FMC_CG_TXERR  5'h04
`define FMC_CRC_INIT  32'hFFFFFFFF
`define FMC_CRC_POLY  32'hEDB88320
`define FMC_CRC_RES   32'hDEBB20E3
`define FMC_MAX_OCT   11'h5DC
`define FMC_MIN_OCT   11'h001
// Header octets ahead of the client data and check octets after it; the
// length limits apply to the client data alone.
`define FMC_HDR_OCT   11'h00E
`define FMC_FCS_OCT   11'h004
`endif

//--- src/fmc_pkg.sv
// Types shared by the fast management coding sublayer.
package fmc_pkg;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       err;
  } fmc_oct_type;
  typedef struct packed {
    logic       frame_ok;
    logic       fcs_bad;
    logic       len_bad;
    logic       code_bad;
  } fmc_rxstat_type;
endpackage

//--- src/fmc_pcs_codec.sv
// Top of the fast management 4B/5B coding sublayer: encoder plus decoder.
`include "fmc_consts.svh"
module fmc_pcs_codec (
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  input  wire logic                    tx_en,
  input  wire logic [7:0]              tx_data,
  input  wire logic                    tx_er,
  output logic [4:0]                   tx_cg,
  output logic                         tx_ack,
  input  wire logic [4:0]              rx_cg,
  output fmc_pkg::fmc_oct_type         rx_oct,
  output logic                         rx_sof,
  output logic                         rx_eof,
  output fmc_pkg::fmc_rxstat_type      rx_stat
);
  typedef enum logic [2:0] {FMC_TX_IDLE, FMC_TX_SSD2, FMC_TX_HI, FMC_TX_LO,
                            FMC_TX_ESD1, FMC_TX_ESD2} fmc_txst_type;

  // ==========================================================
  // Reset release
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ==========================================================
  // Encoder
  function automatic logic [4:0] fmc_enc(input logic [3:0] n);
    unique case (n)
      4'h0: return 5'h1E;
      4'h1: return 5'h09;
      4'h2: return 5'h14;
      4'h3: return 5'h15;
      4'h4: return 5'h0A;
      4'h5: return 5'h0B;
      4'h6: return 5'h0E;
      4'h7: return 5'h0F;
      4'h8: return 5'h12;
      4'h9: return 5'h13;
      4'hA: return 5'h16;
      4'hB: return 5'h17;
      4'hC: return 5'h1A;
      4'hD: return 5'h1B;
      4'hE: return 5'h1C;
      4'hF: return 5'h1D;
    endcase
  endfunction

  fmc_txst_type st_r;
  fmc_txst_type st_nxt;
  logic [7:0]   oct_r;
  logic         err_r;
  logic [4:0]   cg_nxt;

  // The MAC is never stalled: one octet is taken every two cycles while
  // the frame is open, which is the line's nibble rate.
  wire take_w = tx_en && (st_r == FMC_TX_SSD2 || st_r == FMC_TX_LO);

  always_comb begin
    st_nxt = st_r;
    cg_nxt = `FMC_CG_IDLE;
    unique case (st_r)
      FMC_TX_IDLE: begin
        // One idle always follows the end pair, so back-to-back frames
        // still have fill between streams.
        if (tx_en && tx_cg != `FMC_CG_ESD2) begin
          cg_nxt = `FMC_CG_SSD1;
          st_nxt = FMC_TX_SSD2;
        end
      end
      FMC_TX_SSD2: begin
        cg_nxt = `FMC_CG_SSD2;
        st_nxt = tx_en ? FMC_TX_HI : FMC_TX_ESD1;
      end
      FMC_TX_HI: begin
        cg_nxt = err_r ? `FMC_CG_TXERR : fmc_enc(oct_r[7:4]);
        st_nxt = FMC_TX_LO;
      end
      FMC_TX_LO: begin
        cg_nxt = err_r ? `FMC_CG_TXERR : fmc_enc(oct_r[3:0]);
        st_nxt = tx_en ? FMC_TX_HI : FMC_TX_ESD1;
      end
      FMC_TX_ESD1: begin
        cg_nxt = `FMC_CG_ESD1;
        st_nxt = FMC_TX_ESD2;
      end
      FMC_TX_ESD2: begin
        cg_nxt = `FMC_CG_ESD2;
        st_nxt = FMC_TX_IDLE;
      end
      default: begin
        st_nxt = FMC_TX_IDLE;
      end
    endcase
  end

  // The MAC appends the FCS; frame length is the MAC's to keep.
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r   <= FMC_TX_IDLE;
      oct_r  <= 8'h00;
      err_r  <= 1'b0;
      tx_cg  <= `FMC_CG_IDLE;
      tx_ack <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      tx_cg  <= cg_nxt;
      tx_ack <= take_w;
      if (take_w) begin
        oct_r <= tx_data;
        err_r <= tx_er;
      end
    end
  end

  // ==========================================================
  // Decoder
  fmc_rx_dec u_rx (
    .core_clk (core_clk),
    .rst_n    (rst_n_r),
    .rx_cg    (rx_cg),
    .rx_oct   (rx_oct),
    .rx_sof   (rx_sof),
    .rx_eof   (rx_eof),
    .rx_stat  (rx_stat)
  );

  property p_tx_start;
    @(posedge core_clk) disable iff (!rst_n_r)
      (tx_cg == `FMC_CG_SSD1) |=> (tx_cg == `FMC_CG_SSD2);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start pair broken");

  property p_tx_end;
    @(posedge core_clk) disable iff (!rst_n_r)
      (tx_cg == `FMC_CG_ESD1) |=> (tx_cg == `FMC_CG_ESD2) ##1 (tx_cg == `FMC_CG_IDLE);
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("end pair broken");

  property p_tx_valid;
    @(posedge core_clk) disable iff (!rst_n_r)
      !(tx_cg == 5'h00 || tx_cg == 5'h10 || tx_cg == 5'h19 || tx_cg == 5'h01);
  endproperty
  a_tx_valid: assert property (p_tx_valid) else $error("invalid code sent");

  property p_tx_nibble;
    @(posedge core_clk) disable iff (!rst_n_r)
      (st_r == FMC_TX_HI && !err_r) |=> (tx_cg == fmc_enc($past(oct_r[7:4])));
  endproperty
  a_tx_nibble: assert property (p_tx_nibble) else $error("high nibble wrong");
endmodule

//--- verif/fmc_peer.sv
// Peer model: relays transmit code-groups back, or injects a chosen code.
module fmc_peer (
  input  wire logic       core_clk,
  input  wire logic [4:0] tx_cg,
  input  wire logic       inj,
  input  wire logic [4:0] inj_cg,
  output logic      [4:0] rx_cg
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_cg = 5'h1F;
  // Every code-group is taken each cycle; the peer never holds the sender off.
  always @(posedge core_clk) begin
    rx_cg <= inj ? inj_cg : tx_cg;
  end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the fast management 4B/5B coding sublayer.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    core_clk, arst_n, tx_en, tx_er, inj, tx_ack, rx_sof, rx_eof;
  logic [7:0]              tx_data;
  logic [4:0]              tx_cg, rx_cg, inj_cg;
  fmc_pkg::fmc_oct_type    rx_oct;
  fmc_pkg::fmc_rxstat_type rx_stat, stat_r;
  int                      errors, checked, cycles, err_seen, bad_seen, sof_seen, eof_seen;
  logic [4:0]              txq[$];
  logic [7:0]              rxq[$];
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  fmc_pcs_codec dut (.core_clk(core_clk), .arst_n(arst_n), .tx_en(tx_en), .tx_data(tx_data),
    .tx_er(tx_er), .tx_cg(tx_cg), .tx_ack(tx_ack), .rx_cg(rx_cg), .rx_oct(rx_oct),
    .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_stat(rx_stat));
  fmc_peer peer (.core_clk(core_clk), .tx_cg(tx_cg), .inj(inj), .inj_cg(inj_cg), .rx_cg(rx_cg));
  // ==========================================================================
  // Clock, monitor and timeout
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail("timeout");
      summarize();
    end
    if (rx_sof === 1'b1) sof_seen++;
    if (rx_eof === 1'b1) eof_seen++;
    if (tx_cg !== 5'h1F) txq.push_back(tx_cg);
    if (rx_oct.valid === 1'b1) rxq.push_back(rx_oct.data);
    if (rx_oct.err === 1'b1) err_seen++;
    if (rx_stat.code_bad === 1'b1) bad_seen++;
    if (rx_eof === 1'b1) stat_r = rx_stat;
  end
  // ==========================================================================
  // Helpers
  task automatic fail(input string m);
    errors++;
    $display("Error %0t: %s", $time, m);
  endtask
  task automatic cmp_cg(input logic [4:0] g, input logic [4:0] e);
    checked++;
    if (g !== e) fail($sformatf("code %h expected %h", g, e));
  endtask
  task automatic cmp_oct(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) fail($sformatf("octet %h expected %h", g, e));
  endtask
  task automatic cmp_bit(input logic g, input logic e, input string m);
    checked++;
    if (g !== e) fail(m);
  endtask
  // Reflected CRC-32 over the octets; the check word goes out low byte first.
  function automatic void add_fcs(ref logic [7:0] f[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < f.size(); i++) begin
      c ^= {24'h0, f[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    c = ~c;
    for (int i = 0; i < 4; i++) f.push_back(c[8*i +: 8]);
  endfunction
  // The first sixteen octets 00..FF use every nibble value in both halves.
  function automatic void make(ref logic [7:0] f[$], input int n = 16);
    f.delete();
    for (int i = 0; i < n; i++) f.push_back(8'(i * 17));
    add_fcs(f);
  endfunction
  task automatic wait_ack();
    for (int n = 0; n < 4; n++) begin
      @(posedge core_clk);
      if (tx_ack === 1'b1) return;
    end
    fail("no tx_ack");
  endtask
  task automatic send(input logic [7:0] f[$], input int ei);
    txq.delete();
    rxq.delete();
    err_seen = 0;
    bad_seen = 0;
    sof_seen = 0;
    eof_seen = 0;
    stat_r = '0;
    @(posedge core_clk);
    tx_en <= 1'b1;
    tx_data <= f[0];
    tx_er <= (ei == 0);
    for (int k = 1; k <= f.size(); k++) begin
      wait_ack();
      tx_data <= (k < f.size()) ? f[k % f.size()] : 8'h00;
      tx_er <= (ei == k);
      if (k == f.size()) tx_en <= 1'b0;
    end
    repeat (12) @(posedge core_clk);
  endtask
  // Expected wire: start pair, high then low nibble per octet, end pair, then idle.
  task automatic check_tx(input logic [7:0] f[$], input int ei);
    logic [4:0] e[$];
    e = '{5'h18, 5'h11};
    for (int k = 0; k < f.size(); k++) begin
      e.push_back(k == ei ? 5'h04 : ENC[f[k][7:4]]);
      e.push_back(k == ei ? 5'h04 : ENC[f[k][3:0]]);
    end
    e.push_back(5'h0D);
    e.push_back(5'h07);
    cmp_bit(txq.size() == e.size(), 1'b1, "code count");
    foreach (e[i]) cmp_cg(txq[i], e[i]);
    cmp_cg(tx_cg, 5'h1F);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_good();
    logic [7:0] f[$];
    make(f);
    send(f, -1);
    check_tx(f, -1);
    cmp_bit(rxq.size() == f.size(), 1'b1, "octet count");
    foreach (f[i]) cmp_oct(rxq[i], f[i]);
    cmp_bit(stat_r.frame_ok, 1'b1, "frame_ok");
    cmp_bit(stat_r.len_bad | stat_r.fcs_bad | stat_r.code_bad, 1'b0, "status flags");
    cmp_bit(sof_seen == 1, 1'b1, "rx_sof count");
    cmp_bit(eof_seen == 1, 1'b1, "rx_eof count");
    cmp_bit(bad_seen + err_seen == 0, 1'b1, "spurious error");
    $display("test good done");
  endtask
  task automatic t_txerr();
    logic [7:0] f[$];
    make(f);
    send(f, 3);
    check_tx(f, 3);
    cmp_bit(err_seen > 0, 1'b1, "no err");
    cmp_bit(stat_r.frame_ok, 1'b0, "bad frame passed");
    $display("test txerr done");
  endtask
  task automatic t_fcs();
    logic [7:0] f[$];
    make(f);
    f[f.size()-1] ^= 8'h01;
    send(f, -1);
    cmp_bit(stat_r.fcs_bad, 1'b1, "fcs_bad");
    cmp_bit(stat_r.frame_ok, 1'b0, "frame_ok");
    cmp_bit(txq.size() == 2 * f.size() + 4, 1'b1, "resent");
    $display("test fcs done");
  endtask
  task automatic t_invalid();
    logic [7:0] f[$];
    logic [4:0] bad[3] = '{5'h00, 5'h10, 5'h19};
    make(f);
    foreach (bad[j]) begin
      fork
        send(f, -1);
        begin
          repeat (12) @(posedge core_clk);
          inj <= 1'b1;
          inj_cg <= bad[j];
          @(posedge core_clk);
          inj <= 1'b0;
        end
      join
      cmp_bit(bad_seen > 0, 1'b1, "code_bad");
      cmp_bit(stat_r.frame_ok, 1'b0, "frame_ok");
    end
    $display("test invalid done");
  endtask
  task automatic t_reset();
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    cmp_cg(tx_cg, 5'h1F);
    cmp_bit(tx_ack | rx_sof | rx_eof | rx_oct.valid | rx_oct.err | (|rx_stat), 1'b0,
            "reset outputs");
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    $display("test reset done");
  endtask
  // Client data of 1 and 1500 octets pass; one fewer or one more is refused.
  task automatic t_len();
    logic [7:0] f[$];
    int         n[4] = '{15, 1514, 14, 1515};
    foreach (n[j]) begin
      make(f, n[j]);
      send(f, -1);
      cmp_bit(stat_r.len_bad, j > 1, "len_bad");
      cmp_bit(stat_r.frame_ok, j < 2, "frame_ok");
    end
    $display("test len done");
  endtask
  task automatic summarize();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    tx_en = 1'b0;
    tx_er = 1'b0;
    tx_data = 8'h00;
    inj = 1'b0;
    inj_cg = 5'h1F;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_good();
    t_txerr();
    t_fcs();
    t_reset();
    t_invalid();
    t_len();
    summarize();
  end
endmodule
